/* File: rtl/hts_pkg.sv */
// Shared constants and types for the humidity and temperature serial target.
package hts_pkg;

  // Seven-bit bus address that the target answers to.
  localparam logic [6:0] BUS_ADDR = 7'h38;

  // Command codes received as the second byte of a write.
  localparam logic [7:0] CMD_INIT = 8'hE1;
  localparam logic [7:0] CMD_MEAS = 8'hAC;
  localparam logic [7:0] CMD_SRST = 8'hBA;

  // Field positions inside the status byte.
  localparam int STS_BUSY_BIT = 7;
  localparam int STS_MODE_HI  = 6;
  localparam int STS_MODE_LO  = 5;
  localparam int STS_CAL_BIT  = 3;

  // Mode codes and reset values of the status fields.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  localparam logic       CAL_RESET   = 1'b0;
  localparam logic [1:0] MODE_RESET  = MODE_NORMAL;

  // Timing figures in their own units and the clock rate.
  localparam int CLK_KHZ     = 250000;
  localparam int PWRUP_MS    = 20;
  localparam int SRST_MS     = 20;
  localparam int MEAS_MS     = 75;
  localparam int PWRUP_CYC   = PWRUP_MS * CLK_KHZ;
  localparam int SRST_CYC    = SRST_MS * CLK_KHZ;
  localparam int MEAS_CYC    = MEAS_MS * CLK_KHZ;
  localparam int TMR_W       = 25;

  // Result layout: one status byte and five packed data bytes.
  localparam int RAW_W       = 20;
  localparam int DATA_BYTES  = 5;
  localparam int IDX_W       = 3;

  // One-hot states of the serial engine.
  typedef enum logic [4:0] {
    HTS_IDLE = 5'b0_0001,
    HTS_RX   = 5'b0_0010,
    HTS_ACK  = 5'b0_0100,
    HTS_TX   = 5'b0_1000,
    HTS_RACK = 5'b1_0000
  } hts_state_type;

endpackage

/* File: rtl/hts_res_if.sv */
// Connection between the serial engine and the result byte store.
`timescale 1ns/1ps
interface hts_res_if;
  logic                                wr_en;    // Capture pulse.
  logic [hts_pkg::RAW_W-1:0]           hum;      // Raw humidity word.
  logic [hts_pkg::RAW_W-1:0]           tmp;      // Raw temperature word.
  logic [hts_pkg::IDX_W-1:0]           rd_idx;   // Byte index to read.
  logic [7:0]                          rd_data;  // Registered read byte.

  modport engine (output wr_en, output hum, output tmp,
                  output rd_idx, input rd_data);
  modport store  (input wr_en, input hum, input tmp,
                  input rd_idx, output rd_data);
endinterface

/* File: rtl/hts_res_mem.sv */
// Store of the five packed result bytes with a registered read port.
`timescale 1ns/1ps
module hts_res_mem (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  hts_res_if.store  res
);

  // Five result bytes; index 0 is the first data byte after status.
  logic [7:0] mem_q [hts_pkg::DATA_BYTES];

  // Capture packs humidity then temperature, most significant bit first.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < hts_pkg::DATA_BYTES; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (res.wr_en) begin
      mem_q[0] <= res.hum[19:12];
      mem_q[1] <= res.hum[11:4];
      mem_q[2] <= {res.hum[3:0], res.tmp[19:16]};
      mem_q[3] <= res.tmp[15:8];
      mem_q[4] <= res.tmp[7:0];
    end
  end

  // Read data comes from a register; out-of-range indices give all ones.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res.rd_data <= 8'h00;
    end else if (res.rd_idx == 3'h0 || res.rd_idx > 3'h5) begin
      res.rd_data <= 8'hFF;
    end else begin
      res.rd_data <= mem_q[res.rd_idx - 3'h1];
    end
  end

endmodule

/* File: rtl/hts_target.sv */
// Serial target engine: framing, addressing, commands, status and results.
`timescale 1ns/1ps
// How it works
// - Busy after power-up until settling time ends.
// - Start condition opens transfer, bus busy.
// - Stop condition ends transfer, bus idle.
// - First byte holds address and direction bit.
// - Acknowledge received byte after eighth falling edge.
// - Initialization command enables calibration.
// - Trigger command starts combined conversion.
// - Status bit seven shows busy converting or settling.
// - Status bits six-five show operating mode.
// - Status bit three shows calibration; others zero.
// - Soft reset reinitializes and restores defaults.
// - Soft reset finishes within settling time.
// - Read bits change after falling edge only.
module hts_target #(
  parameter int PWRUP_CYC = hts_pkg::PWRUP_CYC,  // Power-up settling.
  parameter int SRST_CYC  = hts_pkg::SRST_CYC,   // Soft reset settling.
  parameter int MEAS_CYC  = hts_pkg::MEAS_CYC    // Conversion time.
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [19:0] raw_humidity_value_in,
  input  wire logic [19:0] raw_temp_value_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic [7:0]       status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling and bus conditions.
  logic scl_q;   // Previous clock line level.
  logic sda_q;   // Previous data line level.

  // Inputs are synchronous, so one stage of history suffices for edges.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine.
  hts_pkg::hts_state_type state_q;     // Engine state.
  logic [3:0]             cnt_q;       // Bits done in the current byte.
  logic [7:0]             shift_q;     // Received byte.
  logic [7:0]             tx_q;        // Byte being sent.
  logic                   first_q;     // Next byte is the address byte.
  logic                   read_q;      // Transfer direction is read.
  logic                   nack_q;      // Host declined another byte.
  logic [2:0]             idx_q;       // Next result byte to send.
  logic                   cmd_stb;     // Command byte accepted.
  logic                   addr_ok;
  logic [7:0]             status_c;
  hts_res_if res ();

  assign addr_ok = (shift_q[7:1] == hts_pkg::BUS_ADDR);
  assign cmd_stb = (state_q == hts_pkg::HTS_RX) && scl_fall &&
                   (cnt_q == 4'h8) && !first_q;

  // One process owns the state, counters and the open-drain data driver.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q    <= hts_pkg::HTS_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      first_q    <= 1'b0;
      read_q     <= 1'b0;
      nack_q     <= 1'b0;
      idx_q      <= 3'h0;
      sda_oe_out <= 1'b0;
    end else if (start_c) begin
      // A repeated start is treated the same as a fresh one.
      state_q    <= hts_pkg::HTS_RX;
      cnt_q      <= 4'h0;
      first_q    <= 1'b1;
      idx_q      <= 3'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_c) begin
      state_q    <= hts_pkg::HTS_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_q)
        hts_pkg::HTS_RX: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_in};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (first_q && !addr_ok) begin
              state_q <= hts_pkg::HTS_IDLE;
            end else begin
              state_q    <= hts_pkg::HTS_ACK;
              sda_oe_out <= 1'b1;
              if (first_q) begin
                read_q <= shift_q[0];
              end
            end
            first_q <= 1'b0;
          end
        end
        hts_pkg::HTS_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (read_q) begin
              // Status goes first, its top bit driven at this fall.
              state_q    <= hts_pkg::HTS_TX;
              tx_q       <= status_c;
              sda_oe_out <= ~status_c[7];
              idx_q      <= 3'h1;
            end else begin
              state_q    <= hts_pkg::HTS_RX;
              sda_oe_out <= 1'b0;
            end
          end
        end
        hts_pkg::HTS_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              state_q    <= hts_pkg::HTS_RACK;
              sda_oe_out <= 1'b0;
            end else begin
              tx_q       <= {tx_q[6:0], 1'b1};
              sda_oe_out <= ~tx_q[6];
              cnt_q      <= cnt_q + 4'h1;
            end
          end
        end
        hts_pkg::HTS_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_in;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= hts_pkg::HTS_IDLE;
            end else begin
              state_q    <= hts_pkg::HTS_TX;
              tx_q       <= res.rd_data;
              sda_oe_out <= ~res.rd_data[7];
              cnt_q      <= 4'h0;
              idx_q      <= idx_q + 3'h1;
            end
          end
        end
        default: begin
          state_q <= hts_pkg::HTS_IDLE;
        end
      endcase
    end
  end

  // The line is only ever pulled low, so the driven level is constant.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution and settling timer.
  logic [hts_pkg::TMR_W-1:0] tmr_q;   // Cycles left of the busy period.
  logic                      busy_q;  // Operation or settling running.
  logic                      meas_q;  // A conversion owns the timer.
  logic                      cal_q;   // Calibration enabled.
  logic [1:0]                mode_q;  // Present operating mode.

  // Commands during busy are acknowledged but ignored, except soft reset.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr_q  <= hts_pkg::TMR_W'(PWRUP_CYC);
      busy_q <= 1'b1;
      meas_q <= 1'b0;
      cal_q  <= hts_pkg::CAL_RESET;
      mode_q <= hts_pkg::MODE_RESET;
    end else if (cmd_stb && shift_q == hts_pkg::CMD_SRST) begin
      tmr_q  <= hts_pkg::TMR_W'(SRST_CYC);
      busy_q <= 1'b1;
      meas_q <= 1'b0;
      cal_q  <= hts_pkg::CAL_RESET;
      mode_q <= hts_pkg::MODE_RESET;
    end else if (busy_q) begin
      if (tmr_q <= hts_pkg::TMR_W'(1)) begin
        busy_q <= 1'b0;
        meas_q <= 1'b0;
        tmr_q  <= '0;
      end else begin
        tmr_q <= tmr_q - hts_pkg::TMR_W'(1);
      end
    end else if (cmd_stb && shift_q == hts_pkg::CMD_INIT) begin
      cal_q  <= 1'b1;
      mode_q <= hts_pkg::MODE_NORMAL;
    end else if (cmd_stb && shift_q == hts_pkg::CMD_MEAS) begin
      tmr_q  <= hts_pkg::TMR_W'(MEAS_CYC);
      busy_q <= 1'b1;
      meas_q <= 1'b1;
    end
  end

  // Results are latched as conversion ends; scaling is left to the host.
  assign res.wr_en  = busy_q && meas_q && tmr_q <= hts_pkg::TMR_W'(1);
  assign res.hum    = raw_humidity_value_in;
  assign res.tmp    = raw_temp_value_in;
  assign res.rd_idx = idx_q;
  hts_res_mem u_mem (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .res        (res)
  );

  // Status byte; reserved bits stay zero.
  always_comb begin
    status_c = 8'h00;
    status_c[hts_pkg::STS_BUSY_BIT] = busy_q;
    status_c[hts_pkg::STS_MODE_HI:hts_pkg::STS_MODE_LO] = mode_q;
    status_c[hts_pkg::STS_CAL_BIT] = cal_q;
  end

  // Registered copy of the status for observation.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_out <= 8'h80;
    end else begin
      status_out <= status_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  start_frame_a: assert property (start_c |=>
    state_q == hts_pkg::HTS_RX && cnt_q == 4'h0 && !sda_oe_out)
    else $error("start not taken");
  stop_frame_a: assert property (stop_c |=>
    state_q == hts_pkg::HTS_IDLE && !sda_oe_out)
    else $error("stop not taken");
  addr_ack_a: assert property (
    state_q == hts_pkg::HTS_RX && scl_fall && cnt_q == 4'h8 && !start_c &&
    !stop_c && (!first_q || addr_ok) |=> sda_oe_out &&
    state_q == hts_pkg::HTS_ACK) else $error("byte not acknowledged");
  addr_nack_a: assert property (
    state_q == hts_pkg::HTS_RX && scl_fall && cnt_q == 4'h8 && first_q &&
    !addr_ok |=> !sda_oe_out ##1 !sda_oe_out)
    else $error("foreign address acknowledged");
  tx_hold_a: assert property (state_q == hts_pkg::HTS_TX &&
    !scl_fall && !start_c && !stop_c |=> $stable(sda_oe_out))
    else $error("read bit changed off falling edge");
  busy_bit_a: assert property (status_out[7] == $past(busy_q))
    else $error("busy bit wrong");
  mode_bits_a: assert property (status_out[6:5] == $past(mode_q))
    else $error("mode bits wrong");
  cal_bits_a: assert property (status_out[3] == $past(cal_q) &&
    status_out[4] == 1'b0 && status_out[2:0] == 3'h0)
    else $error("calibration or reserved bits wrong");
  meas_start_a: assert property (cmd_stb &&
    shift_q == hts_pkg::CMD_MEAS && !busy_q && !start_c && !stop_c
    |=> busy_q && meas_q ##1 busy_q) else $error("conversion not started");
  srst_a: assert property (cmd_stb && shift_q == hts_pkg::CMD_SRST &&
    !start_c && !stop_c |=> busy_q && !cal_q && mode_q == 2'h0)
    else $error("soft reset did not restore defaults");
  settle_end_a: assert property (busy_q && tmr_q == 25'h000_0001 &&
    !cmd_stb |=> !busy_q) else $error("busy period overran");
  init_cal_a: assert property (cmd_stb &&
    shift_q == hts_pkg::CMD_INIT && !busy_q && !start_c && !stop_c
    |=> cal_q) else $error("init did not enable calibration");

  read_cv: cover property (state_q == hts_pkg::HTS_RACK && scl_fall &&
    !nack_q);
  meas_cv: cover property (res.wr_en);
  nack_cv: cover property (state_q == hts_pkg::HTS_RX && scl_fall &&
    cnt_q == 4'h8 && first_q && !addr_ok);
  srst_cv: cover property (cmd_stb && shift_q == hts_pkg::CMD_SRST);

endmodule

/* File: dv/hts_host_model.sv */
// Behavioural bus controller that stands on the far side of the target.
`timescale 1ns/1ps
module hts_host_model (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output logic      scl_low_out,
  output logic      sda_low_out
);
  // Both lines are only ever pulled low; pull-ups give the high level.
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // Four reference clocks a phase compress the bus rate for simulation; a
  // real host stays within the fast-mode limit, and the static target
  // logic samples both lines each reference clock, so each level must last at least one clock.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // Start, or repeated start: data falls while the clock line is high.
  task automatic start_cond;
    sda_low_out = 1'b0;
    tick(4);
    scl_low_out = 1'b0;
    tick(4);
    sda_low_out = 1'b1;
    tick(4);
    scl_low_out = 1'b1;
    tick(4);
  endtask

  // Stop: data rises while the clock line is high, bus becomes idle.
  task automatic stop_cond;
    sda_low_out = 1'b1;
    tick(4);
    scl_low_out = 1'b0;
    tick(4);
    sda_low_out = 1'b0;
    tick(4);
  endtask

  // One bit slot; data changes only while the clock is low.
  task automatic bit_slot(input logic b, output logic r);
    sda_low_out = ~b;
    tick(4);
    scl_low_out = 1'b0;
    tick(2);
    r = sda_in;
    tick(2);
    scl_low_out = 1'b1;
  endtask

  // Sends a byte MSB first and returns the acknowledge bit (0 = ack).
  task automatic byte_tx(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, ack_n);
  endtask

  // Reads a byte; the last byte is not acknowledged, which ends the read.
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(last, r);
  endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the serial target with a host model.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_in;    // Reference clock, 4 ns period.
  logic        nrst_in;       // Active-low reset.
  logic [19:0] hum;           // Raw humidity fed to the target.
  logic [19:0] tmp;           // Raw temperature fed to the target.
  logic        sda_out;       // Target data level.
  logic        sda_oe_out;    // Target pull-down enable.
  logic [7:0]  status_out;    // Status byte seen at the port.
  logic        scl_low;       // Host pulls the clock line.
  logic        sda_low;       // Host pulls the data line.
  wire         scl_line;      // Resolved clock line.
  wire         sda_line;      // Resolved data line.
  int          err_total;     // Mismatch count.
  int          tests_run;     // Comparison count.
  logic [7:0]  rd_q [6];      // Bytes of the last read.

  // Open-drain lines with pull-ups: any party pulling low wins.
  assign scl_line = ~scl_low;
  assign sda_line = ~(sda_low | (sda_oe_out & ~sda_out));

  hts_target #(.PWRUP_CYC(200), .SRST_CYC(200), .MEAS_CYC(300)) uut (
    .ref_clk_in            (ref_clk_in),
    .nrst_in               (nrst_in),
    .scl_in                (scl_line),
    .sda_in                (sda_line),
    .raw_humidity_value_in (hum),
    .raw_temp_value_in     (tmp),
    .sda_out               (sda_out),
    .sda_oe_out            (sda_oe_out),
    .status_out            (status_out)
  );

  hts_host_model host (
    .ref_clk_in  (ref_clk_in),
    .sda_in      (sda_line),
    .scl_low_out (scl_low),
    .sda_low_out (sda_low)
  );

  // Free-running reference clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write transfer: address byte, then one command byte if acknowledged.
  task automatic wr_cmd(input logic [6:0] adr, input logic [7:0] cmd,
                        input logic exp_nak);
    logic a;
    host.start_cond;
    host.byte_tx({adr, 1'b0}, a);
    chk({7'h00, a}, {7'h00, exp_nak});
    if (!a) begin
      host.byte_tx(cmd, a);
      chk({7'h00, a}, 8'h00);
    end
    host.stop_cond;
  endtask

  // Read transfer of n bytes into rd_q.
  task automatic rd_bytes(input int n);
    logic a;
    host.start_cond;
    host.byte_tx({hts_pkg::BUS_ADDR, 1'b1}, a);
    chk({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host.byte_rx(i == n - 1, rd_q[i]);
    end
    host.stop_cond;
  endtask

  // Polls the status byte until not busy; a spent bound ends the run.
  task automatic wait_idle(input int bound);
    for (int i = 0; i < bound; i++) begin
      rd_bytes(1);
      if (rd_q[0][7] === 1'b0) begin
        return;
      end
    end
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, rd_q[0], 8'h00);
    test_done();
  endtask

  // Full result read, packed bytes expected from the raw inputs. The raw
  // words read back are then scaled as a host would: for the fixed inputs
  // that is 64 percent humidity and minus six degrees after truncation.
  task automatic chk_res(input logic [7:0] stat);
    int h;
    int t;
    rd_bytes(6);
    chk(rd_q[0], stat);
    chk(rd_q[1], hum[19:12]);
    chk(rd_q[2], hum[11:4]);
    chk(rd_q[3], {hum[3:0], tmp[19:16]});
    chk(rd_q[4], tmp[15:8]);
    chk(rd_q[5], tmp[7:0]);
    h = int'({rd_q[1], rd_q[2], rd_q[3][7:4]});
    t = int'({rd_q[3][3:0], rd_q[4], rd_q[5]});
    chk(8'((h * 100) >>> 20), 8'h40);
    chk(8'(((t * 200) >>> 20) - 50), 8'hFA);
  endtask

  // Hang guard far above the cycles the sequence needs.
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    err_total++;
    test_done();
  end

  // Main sequence.
  initial begin
    nrst_in = 1'b0;
    hum = 20'hA_5C3E;
    tmp = 20'h3_91B7;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    nrst_in = 1'b1;
    // Settling after power-up shows as busy, then clears.
    rd_bytes(1);
    chk(rd_q[0], 8'h80);
    wait_idle(20);
    chk(rd_q[0], 8'h00);
    // A foreign address must leave the acknowledge slot released.
    wr_cmd(7'h39, hts_pkg::CMD_INIT, 1'b1);
    rd_bytes(1);
    chk(rd_q[0], 8'h00);
    wr_cmd(hts_pkg::BUS_ADDR, hts_pkg::CMD_INIT, 1'b0);
    rd_bytes(1);
    chk(rd_q[0], 8'h08);
    chk(status_out, 8'h08);
    // Unknown code is acknowledged and changes nothing.
    wr_cmd(hts_pkg::BUS_ADDR, 8'h55, 1'b0);
    rd_bytes(1);
    chk(rd_q[0], 8'h08);
    wr_cmd(hts_pkg::BUS_ADDR, hts_pkg::CMD_MEAS, 1'b0);
    rd_bytes(1);
    chk(rd_q[0], 8'h88);
    wait_idle(40);
    chk_res(8'h08);
    // Soft reset clears calibration and is busy while it settles.
    wr_cmd(hts_pkg::BUS_ADDR, hts_pkg::CMD_SRST, 1'b0);
    rd_bytes(1);
    chk(rd_q[0], 8'h80);
    wait_idle(3);
    chk_res(8'h00);
    test_done();
  end
endmodule
